// *** pkg/adc_port_pkg.sv ***
// constants for the serial converter read-out port
package adc_port_pkg;
    localparam int RESULT_W = 12;
    localparam int PAD_W = 4;
    localparam int WORD_W = 16;
    localparam logic [PAD_W-1:0] PAD_BITS = 4'h0;
    localparam logic [RESULT_W-1:0] RESULT_RST = 12'h000;
    localparam logic [3:0] LAST_BIT = 4'hF;
    localparam logic [3:0] FIRST_BIT = 4'h0;
    localparam logic [3:0] BIT_STEP = 4'h1;
    localparam int CONV_TIME_NS = 1500;
    localparam int SCLK_MAX_MHZ = 20;
    // least time, so rounded up to whole link clock cycles
    localparam int CONV_CYCLES_INT = (CONV_TIME_NS * SCLK_MAX_MHZ + 999) / 1000;
    localparam int CONV_CNT_W = 5;
    localparam logic [CONV_CNT_W-1:0] CONV_CYCLES = CONV_CNT_W'(CONV_CYCLES_INT);
    localparam logic [CONV_CNT_W-1:0] CONV_ONE = 5'h01;
    localparam logic [CONV_CNT_W-1:0] CONV_ZERO = 5'h00;

    typedef enum logic [2:0] {
        LINK_IDLE,
        LINK_WAIT_FS,
        LINK_HOLD,
        LINK_SHIFT
    } link_state_t;
endpackage

// *** pkg/result_xfer_if.sv ***
// word handshake between the link side and the system side
interface result_xfer_if;
    logic req_tgl;
    logic ack_tgl;
    logic [adc_port_pkg::RESULT_W-1:0] word;

    modport link (
        output req_tgl,
        input ack_tgl,
        input word
    );
    modport core (
        input req_tgl,
        output ack_tgl,
        output word
    );
endinterface

// *** rtl/adc_serial_port.sv ***
// serial read-out and framing of a 12-bit converter result
// Overview of operation
// - every conversion yields a 12-bit result that goes out on the serial data line.
// - the host serial clock is the conversion clock; a conversion lasts 1.5 us at 20 MHz.
// - serial data stays high-impedance until select falls or frame sync rises.
// - the result leaves most significant bit first, then in descending order.
// - frame sync marks a frame start and is held high by a host that does not use it.
// - with frame sync high as select falls, the MSB is driven for the first falling edge.
// - with frame sync low as select falls, the MSB is still driven after that fall.
// - with select held low, the MSB is driven after frame sync rises.
// - the word is 16 bits: the 12-bit straight binary result then four filler bits.
// - output bits change on rising serial clock edges for sampling on falling ones.
// - with frame sync control, sampling and conversion start when frame sync falls.
module adc_serial_port (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic frame_sync_input_i,
    input wire logic [adc_port_pkg::RESULT_W-1:0] sample_i,
    output logic sdo_o,
    output logic sdo_oe_o,
    output logic low_power_o
);
    result_xfer_if xfer ();

    result_capture u_capture (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .sample_i(sample_i),
        .xfer(xfer.core)
    );

    // link side, clocked by the host serial clock
    logic rst_meta_r;
    logic rst_link_r;
    logic cs_n_prev_r;
    logic fs_prev_r;
    logic cs_fall;
    logic fs_rise;
    adc_port_pkg::link_state_t state_r;
    adc_port_pkg::link_state_t state_nxt;
    logic [adc_port_pkg::WORD_W-1:0] shift_r;
    logic [adc_port_pkg::WORD_W-1:0] shift_nxt;
    logic [3:0] bit_cnt_r;
    logic [3:0] bit_cnt_nxt;
    logic sdo_r;
    logic sdo_nxt;
    logic oe_r;
    logic oe_nxt;
    logic [adc_port_pkg::CONV_CNT_W-1:0] conv_cnt_r;
    logic [adc_port_pkg::CONV_CNT_W-1:0] conv_cnt_nxt;
    logic busy_r;
    logic busy_nxt;
    logic sent_r;
    logic sent_nxt;
    logic lp_r;
    logic lp_nxt;
    logic req_r;
    logic req_nxt;
    logic ack_meta_r;
    logic ack_sync_r;
    logic ack_seen_r;
    logic ack_seen_nxt;
    logic [adc_port_pkg::RESULT_W-1:0] next_word_r;
    logic [adc_port_pkg::RESULT_W-1:0] next_word_nxt;
    logic lp_meta_r;
    logic lp_sync_r;

    function automatic logic [adc_port_pkg::WORD_W-1:0] frame_word(
        input logic [adc_port_pkg::RESULT_W-1:0] res
    );
        frame_word = {res, adc_port_pkg::PAD_BITS};
    endfunction

    // edges are seen on serial clock edges only, hence the host's idle edge
    assign cs_fall = cs_n_prev_r & ~cs_n_i;
    assign fs_rise = ~fs_prev_r & frame_sync_input_i;

    always_comb begin
        state_nxt = state_r;
        shift_nxt = shift_r;
        bit_cnt_nxt = bit_cnt_r;
        sdo_nxt = sdo_r;
        oe_nxt = oe_r;
        conv_cnt_nxt = conv_cnt_r;
        busy_nxt = busy_r;
        sent_nxt = sent_r;
        req_nxt = req_r;
        ack_seen_nxt = ack_seen_r;
        next_word_nxt = next_word_r;
        // word is stable once the ack toggle has passed two flops
        if (ack_sync_r != ack_seen_r) begin
            ack_seen_nxt = ack_sync_r;
            next_word_nxt = xfer.word;
        end
        // conversion runs on the serial clock
        if (busy_r) begin
            conv_cnt_nxt = conv_cnt_r - adc_port_pkg::CONV_ONE;
            if (conv_cnt_r == adc_port_pkg::CONV_ONE) begin
                busy_nxt = 1'b0;
                req_nxt = ~req_r;
            end
        end
        if (cs_n_i) begin
            state_nxt = adc_port_pkg::LINK_IDLE;
            oe_nxt = 1'b0;
        end else begin
            unique case (state_r)
                adc_port_pkg::LINK_IDLE: begin
                    if (cs_fall || fs_rise) begin
                        shift_nxt = frame_word(next_word_r);
                        sdo_nxt = shift_nxt[adc_port_pkg::WORD_W-1];
                        oe_nxt = 1'b1;
                        bit_cnt_nxt = adc_port_pkg::FIRST_BIT;
                        sent_nxt = 1'b0;
                        if (cs_fall && frame_sync_input_i) begin
                            state_nxt = adc_port_pkg::LINK_SHIFT;
                            busy_nxt = 1'b1;
                            conv_cnt_nxt = adc_port_pkg::CONV_CYCLES;
                        end else if (cs_fall) begin
                            state_nxt = adc_port_pkg::LINK_WAIT_FS;
                        end else begin
                            state_nxt = adc_port_pkg::LINK_HOLD;
                        end
                    end
                end
                adc_port_pkg::LINK_WAIT_FS: begin
                    if (frame_sync_input_i) begin
                        state_nxt = adc_port_pkg::LINK_HOLD;
                    end
                end
                adc_port_pkg::LINK_HOLD: begin
                    if (!frame_sync_input_i) begin
                        state_nxt = adc_port_pkg::LINK_SHIFT;
                        busy_nxt = 1'b1;
                        conv_cnt_nxt = adc_port_pkg::CONV_CYCLES;
                    end
                end
                adc_port_pkg::LINK_SHIFT: begin
                    if (bit_cnt_r == adc_port_pkg::LAST_BIT) begin
                        oe_nxt = 1'b0;
                        sent_nxt = 1'b1;
                        state_nxt = adc_port_pkg::LINK_IDLE;
                    end else begin
                        shift_nxt = {shift_r[adc_port_pkg::WORD_W-2:0], 1'b0};
                        sdo_nxt = shift_r[adc_port_pkg::WORD_W-2];
                        bit_cnt_nxt = bit_cnt_r + adc_port_pkg::BIT_STEP;
                    end
                end
                default: begin
                    state_nxt = adc_port_pkg::LINK_IDLE;
                    oe_nxt = 1'b0;
                end
            endcase
        end
        // low power only once the word is out and the conversion has ended
        lp_nxt = sent_nxt && !busy_nxt && (state_nxt == adc_port_pkg::LINK_IDLE);
    end

    // link reset needs a few serial clock edges to reach this side
    always_ff @(posedge sclk_i) begin
        rst_meta_r <= sys_rst_i;
        rst_link_r <= rst_meta_r;
        ack_meta_r <= xfer.ack_tgl;
        ack_sync_r <= ack_meta_r;
    end

    always_ff @(posedge sclk_i) begin
        if (rst_link_r) begin
            cs_n_prev_r <= 1'b1;
            fs_prev_r <= 1'b1;
            state_r <= adc_port_pkg::LINK_IDLE;
            shift_r <= '0;
            bit_cnt_r <= adc_port_pkg::FIRST_BIT;
            sdo_r <= 1'b0;
            oe_r <= 1'b0;
            conv_cnt_r <= adc_port_pkg::CONV_ZERO;
            busy_r <= 1'b0;
            sent_r <= 1'b0;
            lp_r <= 1'b0;
            req_r <= 1'b0;
            ack_seen_r <= 1'b0;
            next_word_r <= adc_port_pkg::RESULT_RST;
        end else begin
            cs_n_prev_r <= cs_n_i;
            fs_prev_r <= frame_sync_input_i;
            state_r <= state_nxt;
            shift_r <= shift_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            sdo_r <= sdo_nxt;
            oe_r <= oe_nxt;
            conv_cnt_r <= conv_cnt_nxt;
            busy_r <= busy_nxt;
            sent_r <= sent_nxt;
            lp_r <= lp_nxt;
            req_r <= req_nxt;
            ack_seen_r <= ack_seen_nxt;
            next_word_r <= next_word_nxt;
        end
    end

    assign xfer.req_tgl = req_r;

    // low power level crosses into the system clock domain
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            lp_meta_r <= 1'b0;
            lp_sync_r <= 1'b0;
        end else begin
            lp_meta_r <= lp_r;
            lp_sync_r <= lp_meta_r;
        end
    end

    assign sdo_o = sdo_r;
    assign sdo_oe_o = oe_r;
    assign low_power_o = lp_sync_r;
endmodule

// *** rtl/result_capture.sv ***
// system-clock side of the conversion result handshake
module result_capture (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic [adc_port_pkg::RESULT_W-1:0] sample_i,
    result_xfer_if.core xfer
);
    logic req_meta_r;
    logic req_sync_r;
    logic req_seen_r;
    logic req_seen_nxt;
    logic ack_r;
    logic ack_nxt;
    logic [adc_port_pkg::RESULT_W-1:0] word_r;
    logic [adc_port_pkg::RESULT_W-1:0] word_nxt;

    // word stays still from ack toggle until the next request
    always_comb begin
        req_seen_nxt = req_seen_r;
        ack_nxt = ack_r;
        word_nxt = word_r;
        if (req_sync_r != req_seen_r) begin
            req_seen_nxt = req_sync_r;
            word_nxt = sample_i;
            ack_nxt = ~ack_r;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            req_meta_r <= 1'b0;
            req_sync_r <= 1'b0;
            req_seen_r <= 1'b0;
            ack_r <= 1'b0;
            word_r <= adc_port_pkg::RESULT_RST;
        end else begin
            req_meta_r <= xfer.req_tgl;
            req_sync_r <= req_meta_r;
            req_seen_r <= req_seen_nxt;
            ack_r <= ack_nxt;
            word_r <= word_nxt;
        end
    end

    assign xfer.ack_tgl = ack_r;
    assign xfer.word = word_r;
endmodule

// *** sim/adc_serial_port_bench.sv ***
// bench for the serial read-out port
module adc_serial_port_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [adc_port_pkg::RESULT_W-1:0] sample_i = 12'h000;
    logic sclk, cs_n, fs, sdo, sdo_oe, lp;
    logic [15:0] got;
    int n_mismatch = 0;
    int cmp_count = 0;
    int exp_q[$];
    always #5 mclk_i = ~mclk_i;
    spi_host_model host_u (.sclk_o(sclk), .cs_n_o(cs_n), .fs_o(fs), .sdo_i(sdo),
        .sdo_oe_i(sdo_oe));
    adc_serial_port dut_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk),
        .cs_n_i(cs_n), .frame_sync_input_i(fs), .sample_i(sample_i), .sdo_o(sdo),
        .sdo_oe_o(sdo_oe), .low_power_o(lp));
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // eleven frames take about ten microseconds
    initial begin
        #100000;
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(32'h6870));
        exp_q.push_back(0);
        repeat (4) @(negedge mclk_i);
        sys_rst_i = 1'b0;
        repeat (20) @(negedge mclk_i);
        check("low power", 16'h0000, {15'h0000, lp});
        check("enable", 16'h0000, {15'h0000, sdo_oe});
        // modes rotate: select only, select then sync, sync only
        for (int i = 0; i < 9; i++) begin
            @(negedge mclk_i);
            sample_i = 12'($urandom);
            exp_q.push_back(int'(sample_i));
            host_u.read_frame(i % 3, got);
            check("word", {12'(exp_q.pop_front()), 4'h0}, got);
            repeat (60) @(negedge mclk_i);
            check("low power", 16'h0001, {15'h0000, lp});
            check("enable", 16'h0000, {15'h0000, sdo_oe});
        end
        // cut frame: bits already out stay valid, the conversion still lands
        @(negedge mclk_i);
        sample_i = 12'($urandom);
        exp_q.push_back(int'(sample_i));
        host_u.cut_frame(5, got);
        check("cut word", 16'(exp_q.pop_front() >> 7), got);
        repeat (60) @(negedge mclk_i);
        check("low power", 16'h0000, {15'h0000, lp});
        check("enable", 16'h0000, {15'h0000, sdo_oe});
        @(negedge mclk_i);
        sample_i = 12'($urandom);
        exp_q.push_back(int'(sample_i));
        host_u.read_frame(0, got);
        check("word", {12'(exp_q.pop_front()), 4'h0}, got);
        repeat (60) @(negedge mclk_i);
        check("low power", 16'h0001, {15'h0000, lp});
        tally_and_finish();
    end
endmodule

// *** sim/adc_serial_port_sva.sv ***
// pin checks for the serial read-out port
module adc_serial_port_sva (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic frame_sync_input_i,
    input wire logic sdo_o,
    input wire logic sdo_oe_o,
    input wire logic low_power_o
);
    timeunit 1ns;
    timeprecision 100ps;
    sequence cs_start_s;
        $fell(cs_n_i) && frame_sync_input_i && !sdo_oe_o;
    endsequence
    AST_CS_HIGH_OFF: assert property (
        @(posedge sclk_i) disable iff (sys_rst_i) cs_n_i |=> !sdo_oe_o)
        else $error("driving while deselected");
    AST_HIZ_HOLD: assert property (
        @(posedge sclk_i) disable iff (sys_rst_i) !sdo_oe_o && !$fell(cs_n_i)
        && !($rose(frame_sync_input_i) && !cs_n_i) |=> !sdo_oe_o)
        else $error("left high impedance without start");
    AST_CS_START: assert property (
        @(posedge sclk_i) disable iff (sys_rst_i) $fell(cs_n_i) && !sdo_oe_o |=> sdo_oe_o)
        else $error("no drive after select fall");
    AST_FS_START: assert property (
        @(posedge sclk_i) disable iff (sys_rst_i)
        $rose(frame_sync_input_i) && !cs_n_i && !sdo_oe_o |=> sdo_oe_o)
        else $error("no drive after frame sync rise");
    AST_FRAME_LEN: assert property (
        @(posedge sclk_i) disable iff (sys_rst_i)
        cs_start_s ##1 (!cs_n_i)[*8] ##1 (!cs_n_i)[*7] |=> sdo_oe_o ##1 !sdo_oe_o)
        else $error("frame not sixteen bits");
    AST_FS_HOLD: assert property (
        @(posedge sclk_i) disable iff (sys_rst_i)
        $rose(frame_sync_input_i) && !cs_n_i && $stable(sdo_o) |=> ##1 $stable(sdo_o))
        else $error("shift before frame sync fell");
    AST_LP_WAKE: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i) sdo_oe_o [*5] |-> !low_power_o)
        else $error("low power during frame");
    AST_LP_IDLE: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i) $rose(low_power_o) |-> !sdo_oe_o)
        else $error("low power entered while driving");
    COV_CS: cover property (@(posedge sclk_i) cs_start_s);
    COV_FS: cover property (@(posedge sclk_i) $rose(frame_sync_input_i) && !cs_n_i);
    COV_LP: cover property (@(posedge mclk_i) $rose(low_power_o));
endmodule
bind adc_serial_port adc_serial_port_sva chk_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .sclk_i(sclk_i), .cs_n_i(cs_n_i), .frame_sync_input_i(frame_sync_input_i),
    .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .low_power_o(low_power_o));

// *** sim/spi_host_model.sv ***
// host serial port model: link clock, framing and word capture
module spi_host_model (
    output logic sclk_o,
    output logic cs_n_o,
    output logic fs_o,
    input wire logic sdo_i,
    input wire logic sdo_oe_i
);
    timeunit 1ns;
    timeprecision 100ps;
    // released line floats, so a late bit reads as z
    wire logic line_w = sdo_oe_i ? sdo_i : 1'bz;
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        fs_o = 1'b1;
    end
    // free running: select-high edges are needed between frames
    // bench rate is above the host limit; the port logic does not depend on the rate
    always #6 sclk_o = ~sclk_o;
    task automatic read_frame(input int mode, output logic [15:0] word);
        if (mode != 2) begin
            @(negedge sclk_o);
            cs_n_o = 1'b1;
            fs_o = (mode == 0);
            @(negedge sclk_o);
            cs_n_o = 1'b0;
        end
        if (mode != 0) begin
            repeat (2) @(negedge sclk_o);
            fs_o = 1'b1;
            @(negedge sclk_o);
            fs_o = 1'b0;
        end
        for (int i = 0; i < 16; i++) begin
            @(negedge sclk_o);
            word = {word[14:0], line_w};
        end
    endtask
    // select-only frame cut short by raising select after nbits samples
    task automatic cut_frame(input int nbits, output logic [15:0] word);
        word = 16'h0000;
        @(negedge sclk_o);
        cs_n_o = 1'b1;
        fs_o = 1'b1;
        @(negedge sclk_o);
        cs_n_o = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            @(negedge sclk_o);
            word = {word[14:0], line_w};
        end
        cs_n_o = 1'b1;
    endtask
endmodule
